// >>> inc/acb_pkg.sv
// Package for the converter configuration bank: offsets, reset values, field positions and carriers.
package acb_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [3:0] OFS_SETUP_CONFIG        = 4'h0;
  localparam logic [3:0] OFS_INPUT_PAIR_SELECT   = 4'h1;
  localparam logic [3:0] OFS_ANALOG_CONTROL      = 4'h2;
  localparam logic [3:0] OFS_CURRENT_DAC_ONE     = 4'h3;
  localparam logic [3:0] OFS_CURRENT_DAC_TWO     = 4'h4;
  localparam logic [3:0] OFS_OFFSET_DAC_SETTING  = 4'h5;
  localparam logic [3:0] OFS_DIGITAL_IO_STATE    = 4'h6;
  localparam logic [3:0] OFS_PIN_DRIVE_SELECT    = 4'h7;
  localparam logic [3:0] OFS_DECIMATION_LOW      = 4'h8;
  localparam logic [3:0] OFS_MODE_DECIMATION_HI  = 4'h9;
  localparam logic [3:0] OFS_OFFSET_CAL_LOW      = 4'ha;
  localparam logic [3:0] OFS_OFFSET_CAL_MID      = 4'hb;
  localparam logic [3:0] OFS_OFFSET_CAL_HIGH     = 4'hc;
  localparam logic [3:0] OFS_GAIN_CAL_LOW        = 4'hd;
  localparam logic [3:0] OFS_GAIN_CAL_MID        = 4'he;
  localparam logic [3:0] OFS_GAIN_CAL_HIGH       = 4'hf;

  localparam int unsigned REG_COUNT  = 16;
  localparam int unsigned BANK_COUNT = 8;
  localparam int unsigned RAM_BYTES  = 128;

  // ==========================================================================
  // Setup and mode register fields
  // ==========================================================================
  localparam int unsigned SETUP_ID_LSB    = 5;
  localparam int unsigned SETUP_SPEED     = 4;
  localparam int unsigned SETUP_REF_EN    = 3;
  localparam int unsigned SETUP_REF_LEVEL = 2;
  localparam int unsigned SETUP_BUF_EN    = 1;
  localparam int unsigned SETUP_BIT_ORDER = 0;
  localparam int unsigned MODE_READY_BIT  = 7;

  // Factory identification bits; the value is arbitrary.
  localparam logic [2:0] FACTORY_ID = 3'h5;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_SETUP_LOW = 8'h0e;
  localparam logic [7:0] RST_MUX       = 8'h01;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_DIR       = 8'hff;
  localparam logic [7:0] RST_DEC_LOW   = 8'h80;
  localparam logic [7:0] RST_MODE_DEC  = 8'h07;
  localparam logic [7:0] RST_GAIN_MID  = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH = 8'h40;
  localparam logic [6:0] RST_PTR       = 7'h00;

  // Modulator divide ratios selected by the speed bit.
  localparam logic [8:0] MOD_DIV_SLOW = 9'h100;
  localparam logic [8:0] MOD_DIV_FAST = 9'h080;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef enum logic [2:0] {
    ACB_NOP,
    ACB_REG_WR,
    ACB_REG_RD,
    ACB_RAM_WR,
    ACB_RAM_RD,
    ACB_PTR_LOAD,
    ACB_COPY_TO_RAM,
    ACB_COPY_TO_REG
  } acb_cmd_e;

  typedef struct packed {
    logic     valid;
    acb_cmd_e cmd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acb_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } acb_rsp_s;

  typedef struct packed {
    logic       speed_slow;
    logic       ref_enable;
    logic       ref_level_high;
    logic       buffer_enable;
    logic       lsb_first;
  } acb_setup_s;

endpackage

// >>> rtl/acb_bank.sv
// Configuration registers, 128-byte bank RAM, result-ready flag and sync control.
// Function
// - Ready output falls when new result arrives.
// - Ready output rises after result read completes.
// - Ready rises before update; master reads only low.
// - Sync from pin or serial command.
// - Sync pin falling edge clears filter counter.
// - Modulator held in reset while pin low.
// - Conversion resumes three clocks after pin high.
// - Sixteen read/write configuration registers.
// - Result data only through dedicated command.
// - Single register or RAM access moves one byte.
// - Bank copies always move sixteen bytes.
// - Eight banks of sixteen bytes, 128 total.
// - RAM independent of live registers.
// - RAM accessible directly from power-up.
// - Auto-incrementing linear RAM pointer crosses banks.
// - Pointer wraps bank 7 offset F to zero.
// - Address upper nibble bank, lower nibble offset.
// - Checksum of RAM on its own output port; no master command reads it.
// - Speed bit picks divide by 128 or 256.
// - Reference enable and level bits in setup.
// - Buffer enable bit; top three bits read-only ID.
// - Bit order bit affects only outgoing bytes.
// - Mode register bit 7 mirrors ready pin.
`timescale 1ns/1ps
`default_nettype none

module acb_bank (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire acb_pkg::acb_req_s req,
  output acb_pkg::acb_rsp_s      rsp,
  input  wire logic              sync_cmd,
  input  wire logic              conversion_sync_n,
  input  wire logic              result_update_start,
  input  wire logic              result_valid,
  input  wire logic [23:0]       result_data,
  input  wire logic              result_read,
  input  wire logic              result_read_done,
  output logic                   result_ready_n,
  output logic [7:0]             result_byte,
  output logic                   filter_count_clear,
  output logic                   modulator_reset,
  output logic [8:0]             modulator_divide,
  output acb_pkg::acb_setup_s    setup,
  output logic [7:0]             ram_checksum,
  output logic [7:0]             digital_io_out,
  output logic [7:0]             pin_drive_in_n
);
  import acb_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0]  regs_q [REG_COUNT];
  logic [7:0]  ram_q  [RAM_BYTES];
  logic [6:0]  ptr_q;
  logic [2:0]  copy_bank_q;
  logic [4:0]  copy_cnt_q;
  logic        copy_dir_q;
  logic        copy_busy_q;
  logic [7:0]  sum_q;
  logic        sync_meta_q;
  logic        sync_q;
  logic        sync_prev_q;
  logic [23:0] result_q;
  logic [1:0]  result_sel_q;

  function automatic logic [7:0] bit_reverse(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Outgoing bytes honour the bit-order setting; incoming bytes never do.
  function automatic logic [7:0] out_byte(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? bit_reverse(v) : v;
  endfunction

  // Setup reads back the identification field in place of the stored bits.
  function automatic logic [7:0] reg_view(input logic [3:0] ofs);
    logic [7:0] v;
    v = regs_q[ofs];
    if (ofs == OFS_SETUP_CONFIG) begin
      v[7:SETUP_ID_LSB] = FACTORY_ID;
    end else if (ofs == OFS_MODE_DECIMATION_HI) begin
      v[MODE_READY_BIT] = result_ready_n;
    end
    return v;
  endfunction

  // ==========================================================================
  // Sync pin synchroniser and modulator control
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_meta_q <= 1'b1;
      sync_q      <= 1'b1;
      sync_prev_q <= 1'b1;
    end else begin
      sync_meta_q <= conversion_sync_n;
      sync_q      <= sync_meta_q;
      sync_prev_q <= sync_q;
    end
  end

  // The command path gives a one-cycle pulse; the pin path holds reset while low.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      filter_count_clear <= 1'b0;
      modulator_reset    <= 1'b0;
    end else begin
      filter_count_clear <= (sync_prev_q & ~sync_q) | sync_cmd;
      modulator_reset    <= ~sync_q;
    end
  end

  // ==========================================================================
  // Result-ready flag
  // ==========================================================================
  // A new result wins over a read completing in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_ready_n <= 1'b1;
      result_q       <= 24'h00_0000;
    end else if (result_valid) begin
      result_ready_n <= 1'b0;
      result_q       <= result_data;
    end else if (result_update_start || result_read_done) begin
      result_ready_n <= 1'b1;
    end
  end

  // Result bytes come out most significant first through a dedicated read.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_sel_q <= 2'd0;
      result_byte  <= 8'h00;
    end else if (result_read_done) begin
      result_sel_q <= 2'd0;
    end else if (result_read && !result_ready_n) begin
      case (result_sel_q)
        2'd0:    result_byte <= out_byte(result_q[23:16], regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER]);
        2'd1:    result_byte <= out_byte(result_q[15:8], regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER]);
        default: result_byte <= out_byte(result_q[7:0], regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER]);
      endcase
      result_sel_q <= (result_sel_q == 2'd2) ? 2'd0 : result_sel_q + 2'd1;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regs_q[OFS_SETUP_CONFIG]       <= RST_SETUP_LOW;
      regs_q[OFS_INPUT_PAIR_SELECT]  <= RST_MUX;
      regs_q[OFS_ANALOG_CONTROL]     <= RST_ZERO;
      regs_q[OFS_CURRENT_DAC_ONE]    <= RST_ZERO;
      regs_q[OFS_CURRENT_DAC_TWO]    <= RST_ZERO;
      regs_q[OFS_OFFSET_DAC_SETTING] <= RST_ZERO;
      regs_q[OFS_DIGITAL_IO_STATE]   <= RST_ZERO;
      regs_q[OFS_PIN_DRIVE_SELECT]   <= RST_DIR;
      regs_q[OFS_DECIMATION_LOW]     <= RST_DEC_LOW;
      regs_q[OFS_MODE_DECIMATION_HI] <= RST_MODE_DEC;
      regs_q[OFS_OFFSET_CAL_LOW]     <= RST_ZERO;
      regs_q[OFS_OFFSET_CAL_MID]     <= RST_ZERO;
      regs_q[OFS_OFFSET_CAL_HIGH]    <= RST_ZERO;
      regs_q[OFS_GAIN_CAL_LOW]       <= RST_ZERO;
      regs_q[OFS_GAIN_CAL_MID]       <= RST_GAIN_MID;
      regs_q[OFS_GAIN_CAL_HIGH]      <= RST_GAIN_HIGH;
    end else if (copy_busy_q && copy_dir_q) begin
      regs_q[copy_cnt_q[3:0]] <= ram_q[{copy_bank_q, copy_cnt_q[3:0]}];
    end else if (req.valid && req.cmd == ACB_REG_WR) begin
      regs_q[req.addr[3:0]] <= req.wdata;
    end
  end

  // ==========================================================================
  // Bank RAM, pointer and bank copy engine
  // ==========================================================================
  // RAM has no reset so it keeps contents apart from register resets.
  always_ff @(posedge sys_clk) begin
    if (copy_busy_q && !copy_dir_q) begin
      ram_q[{copy_bank_q, copy_cnt_q[3:0]}] <= reg_view(copy_cnt_q[3:0]);
    end else if (req.valid && req.cmd == ACB_RAM_WR && !copy_busy_q) begin
      ram_q[ptr_q] <= req.wdata;
    end
  end

  // The 7-bit pointer wraps naturally from bank 7 offset F to bank 0 offset 0.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_q <= RST_PTR;
    end else if (req.valid && !copy_busy_q) begin
      if (req.cmd == ACB_PTR_LOAD) begin
        ptr_q <= {req.addr[6:4], req.addr[3:0]};
      end else if (req.cmd == ACB_RAM_WR || req.cmd == ACB_RAM_RD) begin
        ptr_q <= ptr_q + 7'd1;
      end
    end
  end

  // Copies run one byte per cycle for sixteen cycles; other requests are dropped meanwhile, except register writes during a copy to RAM.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      copy_busy_q <= 1'b0;
      copy_cnt_q  <= 5'd0;
      copy_bank_q <= 3'd0;
      copy_dir_q  <= 1'b0;
    end else if (copy_busy_q) begin
      copy_cnt_q  <= copy_cnt_q + 5'd1;
      copy_busy_q <= (copy_cnt_q != 5'd15);
    end else if (req.valid && (req.cmd == ACB_COPY_TO_RAM || req.cmd == ACB_COPY_TO_REG)) begin
      copy_busy_q <= 1'b1;
      copy_cnt_q  <= 5'd0;
      copy_bank_q <= req.addr[6:4];
      copy_dir_q  <= (req.cmd == ACB_COPY_TO_REG);
    end
  end

  // Running sum over all RAM bytes, rebuilt every 128 cycles.
  logic [6:0] sum_idx_q;
  logic [7:0] sum_acc_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sum_idx_q    <= 7'd0;
      sum_acc_q    <= 8'h00;
      ram_checksum <= 8'h00;
    end else begin
      sum_idx_q <= sum_idx_q + 7'd1;
      if (sum_idx_q == 7'd127) begin
        ram_checksum <= sum_acc_q + ram_q[sum_idx_q];
        sum_acc_q    <= 8'h00;
      end else begin
        sum_acc_q <= sum_acc_q + ram_q[sum_idx_q];
      end
    end
  end

  // ==========================================================================
  // Read answers and decoded outputs
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= 1'b0;
      if (req.valid && !copy_busy_q) begin
        if (req.cmd == ACB_REG_RD) begin
          rsp.valid <= 1'b1;
          rsp.rdata <= out_byte(reg_view(req.addr[3:0]), regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER]);
        end else if (req.cmd == ACB_RAM_RD) begin
          rsp.valid <= 1'b1;
          rsp.rdata <= out_byte(ram_q[ptr_q], regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      setup            <= '0;
      modulator_divide <= MOD_DIV_FAST;
      digital_io_out   <= RST_ZERO;
      pin_drive_in_n   <= RST_DIR;
    end else begin
      setup.speed_slow     <= regs_q[OFS_SETUP_CONFIG][SETUP_SPEED];
      setup.ref_enable     <= regs_q[OFS_SETUP_CONFIG][SETUP_REF_EN];
      setup.ref_level_high <= regs_q[OFS_SETUP_CONFIG][SETUP_REF_LEVEL];
      setup.buffer_enable  <= regs_q[OFS_SETUP_CONFIG][SETUP_BUF_EN];
      setup.lsb_first      <= regs_q[OFS_SETUP_CONFIG][SETUP_BIT_ORDER];
      modulator_divide     <= regs_q[OFS_SETUP_CONFIG][SETUP_SPEED] ? MOD_DIV_SLOW : MOD_DIV_FAST;
      digital_io_out       <= regs_q[OFS_DIGITAL_IO_STATE];
      pin_drive_in_n       <= regs_q[OFS_PIN_DRIVE_SELECT];
    end
  end

endmodule

`default_nettype wire

// >>> tb/acb_bank_checker.sv
// Concurrent checks on the configuration bank ports, bound into the design.
`timescale 1ns/1ps
`default_nettype none
module acb_bank_checker (
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire acb_pkg::acb_req_s   req,
  input wire acb_pkg::acb_rsp_s   rsp,
  input wire logic                sync_cmd,
  input wire logic                conversion_sync_n,
  input wire logic                result_update_start,
  input wire logic                result_valid,
  input wire logic                result_read,
  input wire logic                result_read_done,
  input wire logic                result_ready_n,
  input wire logic [7:0]          result_byte,
  input wire logic                filter_count_clear,
  input wire logic                modulator_reset,
  input wire logic [8:0]          modulator_divide,
  input wire acb_pkg::acb_setup_s setup
);
  import acb_pkg::*;
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_ready_fall; result_valid |=> !result_ready_n; endproperty
  property p_ready_done; result_read_done && !result_valid |=> result_ready_n; endproperty
  property p_ready_upd; result_update_start && !result_valid |=> result_ready_n; endproperty
  property p_read_refused; result_read && result_ready_n |=> $stable(result_byte); endproperty
  property p_rsp_cause;
    rsp.valid |-> $past(req.valid) && ($past(req.cmd) inside {ACB_REG_RD, ACB_RAM_RD});
  endproperty
  property p_sync_cmd; sync_cmd |=> filter_count_clear; endproperty
  property p_sync_fall; $fell(conversion_sync_n) |-> ##3 filter_count_clear; endproperty
  property p_mod_hold; (!conversion_sync_n) [*4] |-> modulator_reset; endproperty
  property p_mod_resume; $rose(conversion_sync_n) |-> ##3 !modulator_reset; endproperty
  // A setup write reaches the divide output two edges later, through the register and its output copy.
  property p_divide;
    req.valid && req.cmd == ACB_REG_WR && req.addr[3:0] == OFS_SETUP_CONFIG |->
      ##2 modulator_divide == ($past(req.wdata[SETUP_SPEED], 2) ? MOD_DIV_SLOW : MOD_DIV_FAST);
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready flag did not fall");
  a_ready_done: assert property (p_ready_done) else $error("ready flag did not rise after read");
  a_ready_upd: assert property (p_ready_upd) else $error("ready flag did not rise before update");
  a_read_refused: assert property (p_read_refused) else $error("result byte moved while not ready");
  a_rsp_cause: assert property (p_rsp_cause) else $error("response without a read request");
  a_sync_cmd: assert property (p_sync_cmd) else $error("sync command did not clear filter");
  a_sync_fall: assert property (p_sync_fall) else $error("sync pin fall did not clear filter");
  a_mod_hold: assert property (p_mod_hold) else $error("modulator not held while pin low");
  a_mod_resume: assert property (p_mod_resume) else $error("modulator did not resume");
  a_divide: assert property (p_divide) else $error("modulator divide disagrees with speed bit");
  c_result: cover property (result_valid ##1 !result_ready_n);
  c_read: cover property (rsp.valid);
  c_sync: cover property (modulator_reset);
endmodule
bind acb_bank acb_bank_checker u_acb_bank_checker (.sys_clk, .srst, .req, .rsp, .sync_cmd,
  .conversion_sync_n, .result_update_start, .result_valid, .result_read, .result_read_done,
  .result_ready_n, .result_byte, .filter_count_clear, .modulator_reset, .modulator_divide, .setup);
`default_nettype wire

// >>> tb/acb_master_model.sv
// Serial master stand-in that issues single byte accesses to the bank.
`timescale 1ns/1ps
`default_nettype none
module acb_master_model (
  input  wire logic              sys_clk,
  output acb_pkg::acb_req_s      req,
  input  wire acb_pkg::acb_rsp_s rsp
);
  import acb_pkg::*;
  initial req = '0;
  // ==========================================================================
  // Access
  // ==========================================================================
  // One byte per request; missing read data comes back unknown so it cannot match.
  task automatic access(input acb_cmd_e c, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    req <= '{1'b1, c, a, d};
    @(negedge sys_clk);
    req.valid <= 1'b0;
    q = (rsp.valid === 1'b1) ? rsp.rdata : 8'hxx;
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_acb_bank.sv
// Self-checking bench for the configuration bank, result flag and sync control.
`timescale 1ns/1ps
`default_nettype none
module tb_acb_bank;
  import acb_pkg::*;
  logic        sys_clk = 1'b0, srst = 1'b1, sync_cmd = 1'b0, conversion_sync_n = 1'b1;
  logic        result_update_start = 1'b0, result_valid = 1'b0, result_read = 1'b0, result_read_done = 1'b0;
  logic [23:0] result_data = 24'hab_cdef;
  wire         acb_req_s req;
  acb_rsp_s    rsp;
  acb_setup_s  setup;
  logic        result_ready_n, filter_count_clear, modulator_reset;
  logic [7:0]  result_byte, ram_checksum, digital_io_out, pin_drive_in_n, q;
  logic [8:0]  modulator_divide;
  logic [7:0]  exp_q [16];
  int          miscompares = 0, tests_run = 0;
  always #4 sys_clk = ~sys_clk;
  acb_bank u_acb_bank (.sys_clk, .srst, .req, .rsp, .sync_cmd, .conversion_sync_n, .result_update_start,
    .result_valid, .result_data, .result_read, .result_read_done, .result_ready_n, .result_byte,
    .filter_count_clear, .modulator_reset, .modulator_divide, .setup, .ram_checksum, .digital_io_out,
    .pin_drive_in_n);
  acb_master_model u_acb_master_model (.sys_clk, .req, .rsp);
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input acb_cmd_e c, input logic [7:0] a, input logic [7:0] d);
    u_acb_master_model.access(c, a, d, q);
  endtask
  task automatic rd(input acb_cmd_e c, input logic [7:0] a, input logic [7:0] want);
    u_acb_master_model.access(c, a, 8'h00, q);
    check("read", q, want);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    exp_q = '{{FACTORY_ID, 5'h0e}, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h80, 8'h87,
              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    foreach (exp_q[i]) rd(ACB_REG_RD, 8'(i), exp_q[i]);
    foreach (exp_q[i]) begin
      wr(ACB_REG_WR, 8'(i), {~4'(i), 4'(i)});
      exp_q[i] = {~4'(i), 4'(i)};
    end
    // Identity bits and the ready mirror ignore writes.
    exp_q[0] = {FACTORY_ID, 5'h10};
    exp_q[9] = 8'he9;
    foreach (exp_q[i]) rd(ACB_REG_RD, 8'(i), exp_q[i]);
    check("speed", {setup.speed_slow, modulator_divide}, {1'b1, MOD_DIV_SLOW});
    check("setup", setup, 5'h10);
    check("io", {digital_io_out, pin_drive_in_n}, 16'h9687);
    wr(ACB_REG_WR, 8'h00, 8'h01);
    rd(ACB_REG_RD, 8'h01, 8'h87);
    wr(ACB_REG_WR, 8'h00, 8'h10);
    wr(ACB_PTR_LOAD, 8'h7e, 8'h00);
    for (int k = 0; k < 6; k++) wr(ACB_RAM_WR, 8'h00, 8'(8'h30 + k));
    wr(ACB_PTR_LOAD, 8'h7e, 8'h00);
    for (int k = 0; k < 4; k++) rd(ACB_RAM_RD, 8'h00, 8'(8'h30 + k));
    wr(ACB_PTR_LOAD, 8'h0f, 8'h00);
    wr(ACB_RAM_WR, 8'h00, 8'hc3);
    wr(ACB_RAM_WR, 8'h00, 8'h3c);
    wr(ACB_PTR_LOAD, 8'h10, 8'h00);
    rd(ACB_RAM_RD, 8'h00, 8'h3c);
    rd(ACB_REG_RD, 8'h04, exp_q[4]);
    wr(ACB_COPY_TO_RAM, 8'h20, 8'h00);
    repeat (18) @(negedge sys_clk);
    wr(ACB_PTR_LOAD, 8'h20, 8'h00);
    foreach (exp_q[i]) rd(ACB_RAM_RD, 8'h00, exp_q[i]);
    wr(ACB_REG_WR, 8'h04, 8'h5a);
    wr(ACB_COPY_TO_REG, 8'h20, 8'h00);
    repeat (18) @(negedge sys_clk);
    rd(ACB_REG_RD, 8'h04, exp_q[4]);
    pulse(result_valid);
    check("ready_n", result_ready_n, 1'b0);
    rd(ACB_REG_RD, 8'h09, 8'h69);
    for (int k = 0; k < 3; k++) begin
      pulse(result_read);
      check("byte", result_byte, 8'(result_data >> (16 - 8 * k)));
    end
    pulse(result_read_done);
    check("ready_n", result_ready_n, 1'b1);
    pulse(result_read);
    check("byte", result_byte, 8'hef);
    pulse(result_valid);
    pulse(result_update_start);
    check("ready_n", result_ready_n, 1'b1);
    @(negedge sys_clk) conversion_sync_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check("mod_reset", modulator_reset, 1'b1);
    conversion_sync_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("mod_reset", modulator_reset, 1'b0);
    pulse(sync_cmd);
    check("filter_clear", filter_count_clear, 1'b1);
    // Fill every RAM byte with its own address, then allow two full sweeps of the running sum.
    wr(ACB_PTR_LOAD, 8'h00, 8'h00);
    for (int k = 0; k < 128; k++) wr(ACB_RAM_WR, 8'h00, 8'(k));
    repeat (260) @(negedge sys_clk);
    check("checksum", ram_checksum, 8'hc0);
    pulse(srst);
    rd(ACB_REG_RD, 8'h01, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
